// >>> rtl/pmc_pkg.sv
// package: register map, field positions and timing for the clock-stop and interrupt control
package pmc_pkg;

  // register indexes; byte address is four times the index
  localparam logic [7:0] PMC_IDX_THR  = 8'h62;
  localparam logic [7:0] PMC_IDX_PM1  = 8'h63;
  localparam logic [7:0] PMC_IDX_CLK  = 8'h65;
  localparam logic [7:0] PMC_IDX_STOP = 8'h66;
  localparam logic [7:0] PMC_IDX_SMI  = 8'h67;
  localparam logic [7:0] PMC_IDX_EN1  = 8'h70;
  localparam logic [7:0] PMC_IDX_EN2  = 8'h71;
  localparam logic [7:0] PMC_IDX_EN3  = 8'h72;
  localparam logic [7:0] PMC_IDX_ST1  = 8'h76;
  localparam logic [7:0] PMC_IDX_ST2  = 8'h77;
  localparam logic [7:0] PMC_IDX_ST3  = 8'h78;

  // reset value and writable-bit masks
  localparam logic [7:0]  PMC_REG_RST    = 8'h00;
  localparam logic [23:0] PMC_CAUSE_RST  = 24'h000000;
  localparam logic [7:0]  PMC_PM1_MASK   = 8'hef;
  localparam logic [7:0]  PMC_CLK_MASK   = 8'h3f;
  localparam logic [7:0]  PMC_STOP_MASK  = 8'hde;
  localparam logic [7:0]  PMC_SMI_MASK   = 8'hc0;
  localparam logic [7:0]  PMC_EN3_MASK   = 8'h7f;
  localparam logic [23:0] PMC_CAUSE_MASK = 24'h3fffff;

  // field positions
  localparam int PMC_PM1_GEN   = 7;
  localparam int PMC_CLK_FON   = 5;
  localparam int PMC_CLK_FOFF  = 4;
  localparam int PMC_CLK_STBY  = 3;
  localparam int PMC_CLK_SUSP  = 1;
  localparam int PMC_STOP_EN   = 7;
  localparam int PMC_STOP_THR  = 6;
  localparam int PMC_STOP_NOWD = 4;
  localparam int PMC_STOP_DLY  = 3;
  localparam int PMC_STOP_SEL  = 1;
  localparam int PMC_SMI_FON   = 7;
  localparam int PMC_SMI_FOFF  = 6;
  localparam int PMC_EVT_STBY  = 12;
  localparam int PMC_EVT_SUSP  = 13;
  localparam int PMC_EVT_APMRD = 22;
  localparam int PMC_EVT_ACT   = 23;

  // timing: times in ns, counts in cycles of the 4 ns clock
  localparam int unsigned PMC_CLK_NS = 4;
  localparam int unsigned PMC_THR_NS [16] = '{27000, 53700, 107000, 215000, 430000,
    860000, 1700000, 3400000, 7000000, 14000000, 28000000, 55000000, 100000000,
    200000000, 400000000, 1000000000};
  localparam int unsigned PMC_DLY_NS [4] = '{430000, 860000, 1700000, 7000000};

  typedef logic [27:0] pmc_cnt_t;
  typedef pmc_cnt_t pmc_thr_tab_t [16];
  typedef pmc_cnt_t pmc_dly_tab_t [4];

  function automatic pmc_cnt_t pmc_cyc(input int unsigned ns);
    pmc_cyc = pmc_cnt_t'((ns + PMC_CLK_NS - 1) / PMC_CLK_NS);
  endfunction

  function automatic pmc_thr_tab_t pmc_thr_tab();
    for (int i = 0; i < 16; i++) begin
      pmc_thr_tab[i] = pmc_cyc(PMC_THR_NS[i]);
    end
  endfunction

  function automatic pmc_dly_tab_t pmc_dly_tab();
    for (int i = 0; i < 4; i++) begin
      pmc_dly_tab[i] = pmc_cyc(PMC_DLY_NS[i]);
    end
  endfunction

  localparam pmc_thr_tab_t PMC_THR_CYC = pmc_thr_tab();
  localparam pmc_dly_tab_t PMC_DLY_CYC = pmc_dly_tab();

  typedef enum logic [1:0] {
    PMC_IDLE = 2'b00,
    PMC_WAIT = 2'b01,
    PMC_HIGH = 2'b10,
    PMC_LOW  = 2'b11
  } pmc_state_t;

endpackage

// >>> rtl/pmc_ctrl.sv
// clock-stop request and management interrupt control with wishbone registers
`timescale 1ns/1ns
module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter pmc_thr_tab_t THR_CYC = PMC_THR_CYC,
  parameter pmc_dly_tab_t DLY_CYC = PMC_DLY_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [9:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic [3:0]  SEL_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // event inputs
  input  wire logic [7:0]  ACCESS_EVT,
  input  wire logic [3:0]  TIMER_EVT,
  input  wire logic        NMI_EVT,
  input  wire logic        BUS_MASTER_REQ,
  input  wire logic [1:0]  IO_TRAP_EVT,
  input  wire logic        DMA_REQ_ANY,
  input  wire logic        IRQ_ANY,
  input  wire logic        EXTERNAL_POWER_EVENT_INPUT,
  input  wire logic        APM_CODE_REQUEST,
  input  wire logic        SW_SMI_REQUEST,
  input  wire logic        USER_TIMER3_EVT,
  input  wire logic        APM_CTRL_READ,
  input  wire logic        STANDBY_EVENT,
  // requests to the processor
  output logic             CPU_CLOCK_HALT_REQUEST,
  output logic             MGMT_INTERRUPT_REQUEST
);

  logic [7:0]  thr_q;
  logic [7:0]  pm1_q;
  logic [7:0]  clk_q;
  logic [7:0]  stop_q;
  logic [7:0]  smi_q;
  logic [23:0] en_q;
  logic [23:0] cause_q;
  logic [23:0] cause_d;
  logic [23:0] s1_q;
  logic [23:0] s2_q;
  logic [23:0] s3_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        req_q;
  logic        req_d;
  logic        halt_q;
  logic        irq_q;
  pmc_state_t  state_q;
  pmc_state_t  state_d;
  pmc_cnt_t    cnt_q;
  pmc_cnt_t    cnt_d;

  // bus decode
  wire [7:0]  idx     = ADR_I[9:2];
  wire        req_bus = CYC_I & STB_I;
  wire        wr      = req_bus & WE_I & ack_q & SEL_I[0];
  wire [7:0]  wdat    = DAT_I[7:0];
  wire        wr_thr  = wr & (idx == PMC_IDX_THR);
  wire        wr_pm1  = wr & (idx == PMC_IDX_PM1);
  wire        wr_clk  = wr & (idx == PMC_IDX_CLK);
  wire        wr_stop = wr & (idx == PMC_IDX_STOP);
  wire        wr_smi  = wr & (idx == PMC_IDX_SMI);
  wire        wr_en1  = wr & (idx == PMC_IDX_EN1);
  wire        wr_en2  = wr & (idx == PMC_IDX_EN2);
  wire        wr_en3  = wr & (idx == PMC_IDX_EN3);
  wire        wr_st1  = wr & (idx == PMC_IDX_ST1);
  wire        wr_st2  = wr & (idx == PMC_IDX_ST2);
  wire        wr_st3  = wr & (idx == PMC_IDX_ST3);

  // read selection, unmapped reads zero
  wire [7:0] rdat =
    (idx == PMC_IDX_THR)  ? thr_q  :
    (idx == PMC_IDX_PM1)  ? pm1_q  :
    (idx == PMC_IDX_CLK)  ? clk_q  :
    (idx == PMC_IDX_STOP) ? stop_q :
    (idx == PMC_IDX_SMI)  ? smi_q  :
    (idx == PMC_IDX_EN1)  ? en_q[7:0]   :
    (idx == PMC_IDX_EN2)  ? en_q[15:8]  :
    (idx == PMC_IDX_EN3)  ? en_q[23:16] :
    (idx == PMC_IDX_ST1)  ? cause_q[7:0]   :
    (idx == PMC_IDX_ST2)  ? cause_q[15:8]  :
    (idx == PMC_IDX_ST3)  ? cause_q[23:16] : PMC_REG_RST;

  // control fields
  wire gen     = pm1_q[PMC_PM1_GEN];
  wire run     = gen & stop_q[PMC_STOP_EN];
  wire thr_en  = stop_q[PMC_STOP_THR];
  wire dly_en  = stop_q[PMC_STOP_DLY];
  wire [1:0] dly_sel = stop_q[PMC_STOP_SEL +: 2];
  wire hfon    = clk_q[PMC_CLK_FON];
  wire hfoff   = clk_q[PMC_CLK_FOFF];
  wire ifon    = smi_q[PMC_SMI_FON];
  wire ifoff   = smi_q[PMC_SMI_FOFF];

  // synchronised events and their rising edges
  wire [23:0] evt_raw = {STANDBY_EVENT, APM_CTRL_READ, DMA_REQ_ANY, IRQ_ANY,
    EXTERNAL_POWER_EVENT_INPUT, APM_CODE_REQUEST, SW_SMI_REQUEST, USER_TIMER3_EVT,
    TIMER_EVT, NMI_EVT, BUS_MASTER_REQ, IO_TRAP_EVT, ACCESS_EVT};
  wire [23:0] rise    = s2_q & ~s3_q;

  // cause latching: set wins over write-one clear
  wire [23:0] set  = rise & en_q & PMC_CAUSE_MASK & {24{gen}};
  wire [23:0] w1c  = {wr_st3 ? wdat : 8'h00, wr_st2 ? wdat : 8'h00, wr_st1 ? wdat : 8'h00};
  assign cause_d   = (cause_q & ~w1c) | set;

  // automatic clock-stop triggers
  wire trig_stby = rise[PMC_EVT_STBY] & clk_q[PMC_CLK_STBY];
  wire trig_susp = rise[PMC_EVT_SUSP] & clk_q[PMC_CLK_SUSP];
  wire trig_apm  = rise[PMC_EVT_APMRD] & en_q[PMC_EVT_APMRD];
  wire trig      = run & (trig_stby | trig_susp | trig_apm);
  wire withdraw  = rise[PMC_EVT_ACT] & ~stop_q[PMC_STOP_NOWD];
  assign req_d   = trig | (req_q & run & ~withdraw);

  // interval length of the current state
  wire pmc_cnt_t lim =
    (state_q == PMC_WAIT) ? DLY_CYC[dly_sel] :
    (state_q == PMC_LOW)  ? THR_CYC[thr_q[7:4]] : THR_CYC[thr_q[3:0]];
  wire done = (cnt_q >= lim - pmc_cnt_t'(1));
  wire live = run & req_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PMC_IDLE: begin
        if (live) begin
          state_d = dly_en ? PMC_WAIT : PMC_HIGH;
        end
      end
      PMC_WAIT: begin
        if (!live) begin
          state_d = PMC_IDLE;
        end else if (done) begin
          state_d = PMC_HIGH;
        end
      end
      PMC_HIGH: begin
        if (!live) begin
          state_d = PMC_IDLE;
        end else if (thr_en && done) begin
          state_d = PMC_LOW;
        end
      end
      PMC_LOW: begin
        if (!live) begin
          state_d = PMC_IDLE;
        end else if (!thr_en || done) begin
          state_d = PMC_HIGH;
        end
      end
    endcase
  end

  assign cnt_d = (state_d != state_q) ? '0 : cnt_q + pmc_cnt_t'(1);

  // output decisions, force-off first
  wire halt_d = hfoff ? 1'b0 : (hfon | (state_q == PMC_HIGH));
  wire irq_d  = ifoff ? 1'b0 : (ifon | (|cause_q));

  // bus handshake and read data
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req_bus & ~ack_q;
      dat_q <= {24'h000000, rdat};
    end
  end

  // control registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      thr_q  <= PMC_REG_RST;
      pm1_q  <= PMC_REG_RST;
      clk_q  <= PMC_REG_RST;
      stop_q <= PMC_REG_RST;
      smi_q  <= PMC_REG_RST;
    end else begin
      if (wr_thr)  thr_q  <= wdat;
      if (wr_pm1)  pm1_q  <= wdat & PMC_PM1_MASK;
      if (wr_clk)  clk_q  <= wdat & PMC_CLK_MASK;
      if (wr_stop) stop_q <= wdat & PMC_STOP_MASK;
      if (wr_smi)  smi_q  <= wdat & PMC_SMI_MASK;
    end
  end

  // enable registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      en_q <= PMC_CAUSE_RST;
    end else begin
      if (wr_en1) en_q[7:0]   <= wdat;
      if (wr_en2) en_q[15:8]  <= wdat;
      if (wr_en3) en_q[23:16] <= wdat & PMC_EN3_MASK;
    end
  end

  // event synchronisers, causes, clock-stop state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s1_q    <= PMC_CAUSE_RST;
      s2_q    <= PMC_CAUSE_RST;
      s3_q    <= PMC_CAUSE_RST;
      cause_q <= PMC_CAUSE_RST;
      req_q   <= 1'b0;
      state_q <= PMC_IDLE;
      cnt_q   <= '0;
      halt_q  <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      s1_q    <= evt_raw;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      cause_q <= cause_d;
      req_q   <= req_d;
      state_q <= state_d;
      cnt_q   <= cnt_d;
      halt_q  <= halt_d;
      irq_q   <= irq_d;
    end
  end

  assign ACK_O                  = ack_q;
  assign DAT_O                  = dat_q;
  assign CPU_CLOCK_HALT_REQUEST = halt_q;
  assign MGMT_INTERRUPT_REQUEST = irq_q;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_halt_fon;
    (hfon && !hfoff) |=> CPU_CLOCK_HALT_REQUEST;
  endproperty
  a_halt_fon: assert property (p_halt_fon) else $error("forced halt not on");

  property p_halt_foff;
    hfoff |=> !CPU_CLOCK_HALT_REQUEST;
  endproperty
  a_halt_foff: assert property (p_halt_foff) else $error("halt not forced off");

  property p_req_cause;
    $rose(req_q) |-> $past(run && (trig_stby || trig_susp || trig_apm));
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without trigger");

  property p_run_gate;
    !run |=> (state_q == PMC_IDLE) && !req_q;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("clock-stop active while off");

  property p_no_throttle;
    (state_q == PMC_HIGH && live && !thr_en) |=> state_q == PMC_HIGH;
  endproperty
  a_no_throttle: assert property (p_no_throttle) else $error("throttled while off");

  property p_withdraw;
    (req_q && withdraw && !trig) |=> !req_q;
  endproperty
  a_withdraw: assert property (p_withdraw) else $error("standby did not withdraw");

  property p_bypass;
    (state_q == PMC_IDLE && state_d != PMC_IDLE) |-> (dly_en == (state_d == PMC_WAIT));
  endproperty
  a_bypass: assert property (p_bypass) else $error("delay choice wrong");

  property p_delay_len;
    (state_q == PMC_WAIT && state_d == PMC_HIGH) |-> cnt_q == DLY_CYC[dly_sel] - 1;
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay length wrong");

  property p_irq_on;
    (ifon && !ifoff) |=> MGMT_INTERRUPT_REQUEST;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("forced interrupt not on");

  property p_irq_off;
    ifoff |=> !MGMT_INTERRUPT_REQUEST;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt not forced off");

  property p_cause_set;
    (set != 24'h000000) |=> ((cause_q & $past(set)) == $past(set));
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause not latched");

  property p_cause_irq;
    ((|cause_q) && !ifoff) |=> MGMT_INTERRUPT_REQUEST;
  endproperty
  a_cause_irq: assert property (p_cause_irq) else $error("cause did not interrupt");

  property p_stby_trig;
    (run && trig_stby) |=> req_q;
  endproperty
  a_stby_trig: assert property (p_stby_trig) else $error("standby expiry ignored");

  property p_susp_trig;
    (run && trig_susp) |=> req_q;
  endproperty
  a_susp_trig: assert property (p_susp_trig) else $error("suspend expiry ignored");

  property p_hi_len;
    (state_q == PMC_HIGH && state_d == PMC_LOW) |-> cnt_q == THR_CYC[thr_q[3:0]] - 1;
  endproperty
  a_hi_len: assert property (p_hi_len) else $error("high interval wrong");

  property p_lo_len;
    (state_q == PMC_LOW && state_d == PMC_HIGH && thr_en) |-> cnt_q == THR_CYC[thr_q[7:4]] - 1;
  endproperty
  a_lo_len: assert property (p_lo_len) else $error("low interval wrong");

  property p_apm_trig;
    (run && trig_apm) |=> req_q;
  endproperty
  a_apm_trig: assert property (p_apm_trig) else $error("port read ignored");

  property p_global_off;
    !gen |=> (cause_q & ~$past(cause_q)) == 24'h000000;
  endproperty
  a_global_off: assert property (p_global_off) else $error("cause latched while off");

  property p_cause_hold;
    (set == 24'h000000 && w1c == 24'h000000) |=> $stable(cause_q);
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause changed unasked");

  property p_irq_quiet;
    (!ifon && cause_q == 24'h000000) |=> !MGMT_INTERRUPT_REQUEST;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without cause");

  property p_halt_quiet;
    (!hfon && state_q != PMC_HIGH) |=> !CPU_CLOCK_HALT_REQUEST;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("halt without reason");

  c_throttle: cover property (state_q == PMC_HIGH ##1 state_q == PMC_LOW);
  c_delay:    cover property (state_q == PMC_WAIT ##1 state_q == PMC_HIGH);
  c_clear:    cover property ((|w1c) && (|(cause_q & w1c)));
  c_irq:      cover property ($rose(MGMT_INTERRUPT_REQUEST));
  c_apm:      cover property (run && trig_apm);

endmodule

// >>> bench/pmc_host_model.sv
// host-side model: watches the halt and interrupt requests, times the halt levels and counts interrupt rises
`timescale 1ns/1ns
module pmc_host_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // requests from the controller
  input  wire logic halt_req,
  input  wire logic irq_req,
  // observed figures
  output int        hi_len,
  output int        lo_len,
  output int        irq_rises
);
  int   run_q;
  logic halt_q;
  logic irq_q;
  always_ff @(posedge clk) begin
    halt_q <= halt_req;
    irq_q  <= irq_req;
    run_q  <= (halt_req !== halt_q) ? 1 : run_q + 1;
    if (!rst_n) begin
      hi_len    <= 0;
      lo_len    <= 0;
      irq_rises <= 0;
    end else begin
      if (irq_req === 1'b1 && irq_q === 1'b0) irq_rises <= irq_rises + 1;
      if (halt_req !== halt_q && halt_q === 1'b1) hi_len <= run_q;
      if (halt_req !== halt_q && halt_q === 1'b0) lo_len <= run_q;
    end
  end
endmodule

// >>> bench/pmc_ctrl_tb_top.sv
// self-checking bench for the clock-stop and management interrupt controller
`timescale 1ns/1ns
module pmc_ctrl_tb_top;
  import pmc_pkg::*;
  function automatic pmc_thr_tab_t mk_thr();
    for (int i = 0; i < 16; i++) begin
      mk_thr[i] = pmc_cnt_t'(4 + i);
    end
  endfunction
  localparam pmc_thr_tab_t THR = mk_thr();
  localparam pmc_dly_tab_t DLY = '{28'h5, 28'h6, 28'h7, 28'h8};
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [9:0]  adr;
  logic [31:0] dat_w;
  logic [3:0]  sel;
  logic [31:0] dat_r;
  logic        ack;
  logic [23:0] evt;
  logic        halt;
  logic        irq;
  int          hi_len;
  int          lo_len;
  int          irq_rises;
  int          bad_count;
  int          check_count;
  int          n;
  int          n0;
  logic [7:0]  idx_tab [6];
  logic [7:0]  msk_tab [6];

  pmc_ctrl #(.THR_CYC(THR), .DLY_CYC(DLY)) dut (
    .CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .DAT_I(dat_w), .SEL_I(sel), .DAT_O(dat_r), .ACK_O(ack),
    .ACCESS_EVT(evt[7:0]), .TIMER_EVT(evt[15:12]), .NMI_EVT(evt[11]),
    .BUS_MASTER_REQ(evt[10]), .IO_TRAP_EVT(evt[9:8]), .DMA_REQ_ANY(evt[21]),
    .IRQ_ANY(evt[20]), .EXTERNAL_POWER_EVENT_INPUT(evt[19]), .APM_CODE_REQUEST(evt[18]),
    .SW_SMI_REQUEST(evt[17]), .USER_TIMER3_EVT(evt[16]), .APM_CTRL_READ(evt[22]),
    .STANDBY_EVENT(evt[23]), .CPU_CLOCK_HALT_REQUEST(halt), .MGMT_INTERRUPT_REQUEST(irq));

  pmc_host_model host (.clk(clk), .rst_n(rst_n), .halt_req(halt), .irq_req(irq),
    .hi_len(hi_len), .lo_len(lo_len), .irq_rises(irq_rises));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                    output logic [7:0] rd);
    int k;
    k = 0;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {idx, 2'b00};
    dat_w <= {24'h000000, wd};
    sel   <= 4'h1;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1);
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack wait", k, 2);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    wb(1'b1, idx, d, x);
    repeat (2) @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    wb(1'b0, idx, 8'h00, x);
    chk("register", x, exp);
  endtask

  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    repeat (4) @(posedge clk);
    evt[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // edges from raising an event until the halt request shows, at most 40
  task automatic lat(input int i, output int c);
    evt[i] <= 1'b1;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (halt !== 1'b1 && c < 40);
    evt[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wlvl(input logic v);
    int k;
    k = 0;
    while (halt !== v && k < 100) begin
      @(posedge clk);
      k++;
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    idx_tab = '{PMC_IDX_CLK, PMC_IDX_STOP, PMC_IDX_SMI, PMC_IDX_EN1, PMC_IDX_EN2, PMC_IDX_EN3};
    msk_tab = '{8'h3f, 8'hde, 8'hc0, 8'hff, 8'hff, 8'h7f};
    {cyc, stb, we, adr, dat_w, sel, evt} = '0;
    rst_n = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("halt", halt, 0);
    chk("irq", irq, 0);
    foreach (idx_tab[k]) rchk(idx_tab[k], 8'h00);
    foreach (idx_tab[k]) begin
      wr(idx_tab[k], 8'hff);
      rchk(idx_tab[k], msk_tab[k]);
    end
    chk("halt", halt, 0);
    chk("irq", irq, 0);
    wr(8'h40, 8'hff);
    rchk(8'h40, 8'h00);
    foreach (idx_tab[k]) wr(idx_tab[k], 8'h00);
    // interrupt sources: gated off, then each one latched and cleared
    wr(PMC_IDX_PM1, 8'h80);
    for (int i = 0; i < 22; i++) pulse(i);
    chk("irq", irq, 0);
    for (int s = 0; s < 3; s++) rchk(PMC_IDX_ST1 + 8'(s), 8'h00);
    wr(PMC_IDX_EN1, 8'hff);
    wr(PMC_IDX_EN2, 8'hff);
    wr(PMC_IDX_EN3, 8'h3f);
    for (int i = 0; i < 22; i++) begin
      pulse(i);
      rchk(PMC_IDX_ST1 + 8'(i / 8), 8'(1 << (i % 8)));
      chk("irq", irq, 1);
      wr(PMC_IDX_ST1 + 8'(i / 8), 8'h00);
      rchk(PMC_IDX_ST1 + 8'(i / 8), 8'(1 << (i % 8)));
      wr(PMC_IDX_ST1 + 8'(i / 8), 8'(1 << (i % 8)));
      rchk(PMC_IDX_ST1 + 8'(i / 8), 8'h00);
      chk("irq", irq, 0);
    end
    pulse(0);
    wr(PMC_IDX_SMI, 8'h40);
    chk("irq", irq, 0);
    wr(PMC_IDX_SMI, 8'h00);
    chk("irq", irq, 1);
    wr(PMC_IDX_ST1, 8'h01);
    wr(PMC_IDX_SMI, 8'h80);
    chk("irq", irq, 1);
    wr(PMC_IDX_SMI, 8'hc0);
    chk("irq", irq, 0);
    wr(PMC_IDX_SMI, 8'h00);
    chk("irq", irq, 0);
    wr(PMC_IDX_PM1, 8'h00);
    pulse(0);
    rchk(PMC_IDX_ST1, 8'h00);
    // automatic clock-stop on timer expiry, every mode code
    wr(PMC_IDX_PM1, 8'h80);
    wr(PMC_IDX_EN1, 8'h00);
    wr(PMC_IDX_EN2, 8'h00);
    wr(PMC_IDX_EN3, 8'h00);
    wr(PMC_IDX_STOP, 8'h80);
    for (int m = 0; m < 4; m++) begin
      for (int t = 0; t < 2; t++) begin
        wr(PMC_IDX_CLK, 8'(m << (2 - 2 * t)));
        lat(12 + t, n);
        chk("halt", halt, (m >= 2));
        pulse(23);
        chk("halt", halt, 0);
      end
    end
    wr(PMC_IDX_CLK, 8'h08);
    lat(12, n0);
    wr(PMC_IDX_CLK, 8'h18);
    chk("halt", halt, 0);
    wr(PMC_IDX_CLK, 8'h08);
    chk("halt", halt, 1);
    wr(PMC_IDX_STOP, 8'h90);
    pulse(23);
    chk("halt", halt, 1);
    wr(PMC_IDX_STOP, 8'h00);
    lat(12, n);
    chk("halt", halt, 0);
    wr(PMC_IDX_CLK, 8'h28);
    chk("halt", halt, 1);
    wr(PMC_IDX_CLK, 8'h08);
    chk("halt", halt, 0);
    // assertion delay, all four selections
    for (int s = 0; s < 4; s++) begin
      wr(PMC_IDX_STOP, 8'h88 | 8'(s << 1));
      lat(12, n);
      chk("delay", n - n0, DLY[s]);
      pulse(23);
    end
    // clock-stop on an APM control port read
    wr(PMC_IDX_STOP, 8'h80);
    wr(PMC_IDX_CLK, 8'h00);
    wr(PMC_IDX_EN3, 8'h40);
    lat(22, n);
    chk("halt", halt, 1);
    pulse(23);
    wr(PMC_IDX_EN3, 8'h00);
    lat(22, n);
    chk("halt", halt, 0);
    // throttling: high code 3, low code 9
    wr(PMC_IDX_THR, 8'h93);
    wr(PMC_IDX_CLK, 8'h08);
    wr(PMC_IDX_STOP, 8'hc0);
    lat(12, n);
    wlvl(1'b0);
    wlvl(1'b1);
    wlvl(1'b0);
    repeat (2) @(posedge clk);
    chk("high time", hi_len, THR[3]);
    chk("low time", lo_len, THR[9]);
    wr(PMC_IDX_PM1, 8'h00);
    chk("halt", halt, 0);
    chk("host irq seen", (irq_rises != 0), 1);
    stop_test();
  end
endmodule
